// File: inc/dmi_pkg.sv
// Register map, field layout and encodings of the DMA interrupt and register block.
`default_nettype none
package dmi_pkg;
    // --------------------------------------------------------------
    // Register indices; byte address is four times the index
    // --------------------------------------------------------------
    localparam int                   NCH          = 3;
    localparam logic [8:0]           IDX_TSEL     = 9'h122;
    localparam logic [8:0]           IDX_OPT      = 9'h124;
    localparam logic [8:0]           IDX_IV       = 9'h126;
    localparam logic [2:0][8:0]      IDX_CH_CTL   = {9'h1E8, 9'h1DC, 9'h1D0};
    localparam logic [2:0][8:0]      IDX_CH_SA    = {9'h1EA, 9'h1DE, 9'h1D2};
    localparam logic [2:0][8:0]      IDX_CH_DA    = {9'h1EE, 9'h1E2, 9'h1D6};
    localparam logic [2:0][8:0]      IDX_CH_SZ    = {9'h1F2, 9'h1E6, 9'h1DA};
    // --------------------------------------------------------------
    // Field layout
    // --------------------------------------------------------------
    localparam int                   OPT_NMI_BIT  = 0;
    localparam int                   CH_REQ_BIT   = 0;
    localparam int                   CH_ABORT_BIT = 1;
    localparam int                   CH_IE_BIT    = 2;
    localparam int                   CH_DONE_BIT  = 3;
    localparam int                   CH_EN_BIT    = 4;
    localparam int                   TSEL_W       = 4;
    localparam logic [15:0]          TSEL_MASK    = 16'h0FFF;
    localparam logic [15:0]          OPT_MASK     = 16'h0001;
    localparam logic [15:0]          CH_CTL_MASK  = 16'h001E;
    localparam logic [15:0]          CTL_RESET    = 16'h0000;
    // --------------------------------------------------------------
    // Trigger select codes
    // --------------------------------------------------------------
    localparam logic [3:0]           TSEL_SW      = 4'h0;
    localparam logic [3:0]           TSEL_DAC     = 4'h5;
    localparam logic [3:0]           TSEL_CONV    = 4'h6;
    localparam logic [3:0]           TSEL_I2C_RX  = 4'hC;
    localparam logic [3:0]           TSEL_I2C_TX  = 4'hD;
    localparam logic [3:0]           TSEL_CHAIN   = 4'hE;
    localparam logic [3:0]           TSEL_EXT     = 4'hF;
    // --------------------------------------------------------------
    // Vector codes and peripheral addresses
    // --------------------------------------------------------------
    localparam logic [15:0]          IV_NONE      = 16'h0000;
    localparam logic [2:0][15:0]     IV_CH        = {16'h0006, 16'h0004, 16'h0002};
    localparam logic [15:0]          CONV_BASE    = 16'h0140;
    localparam logic [15:0]          DAC_DATA_A   = 16'h01C8;
    localparam logic [15:0]          ONE16        = 16'h0001;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10,
        ST_DONE  = 2'b11
    } dmi_state_type;
endpackage
`default_nettype wire

// File: src/dmi_core.sv
// DMA controller interrupt, trigger and register block with one-word transfer engine.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Maskable interrupts are held pending while a transfer runs.
// - With the NMI abort enable set, an NMI aborts a running transfer.
// - A transfer takes the bus even during an interrupt service routine.
// - Each channel's done flag sets when its size counter reaches zero.
// - Interrupt request needs done flag, channel interrupt enable and global enable.
// - All done flags share one vector; only software clears them.
// - Vector reports highest pending enabled channel, channel 0 first.
// - Codes: 0 none, 2 channel 0, 4 channel 1, 6 channel 2.
// - A channel with interrupt disabled does not affect the vector.
// - Any vector access clears the highest pending flag; others raise again.
// - I2C receive flag triggers when its enable is clear; cleared on acknowledge.
// - I2C transmit flag triggers when its enable is clear; cleared on acknowledge.
// - Sequence modes 0/2 use the used memory flag, 1/3 the last one.
// - Converter result flag clears when the engine reads its result register.
// - DAC load flag clears when the engine accesses the DAC data register.
// - Converter transfers run without waking the CPU, in any low-power mode.
// - Address and size registers survive reset; control and vector registers reset.
// - Trigger code 1100 selects the I2C receive flag.
// - Trigger code 1101 selects the I2C transmit flag.
module dmi_core
    import dmi_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          global_irq_enable,
    input  wire logic          cpu_irq_request,
    output logic               cpu_irq_take,
    input  wire logic          nmi_request,
    output logic               cpu_bus_hold,
    output logic               dma_irq,
    output logic               mem_req,
    output logic               mem_we,
    output logic      [15:0]   mem_addr,
    output logic      [15:0]   mem_wdata,
    input  wire logic [15:0]   mem_rdata,
    input  wire logic          mem_ack,
    input  wire logic          i2c_receive_flag,
    input  wire logic          i2c_receive_irq_enable,
    output logic               i2c_receive_flag_clear,
    input  wire logic          i2c_transmit_flag,
    input  wire logic          i2c_transmit_irq_enable,
    output logic               i2c_transmit_flag_clear,
    input  wire logic [15:0]   converter_result_flag,
    input  wire logic [1:0]    conversion_sequence_mode,
    input  wire logic [3:0]    conv_used_index,
    input  wire logic [3:0]    conv_last_index,
    output logic      [15:0]   converter_flag_clear,
    input  wire logic          dac_load_flag,
    output logic               dac_load_flag_clear,
    input  wire logic          ext_trigger
);
    // --------------------------------------------------------------
    // Registers and state
    // --------------------------------------------------------------
    dmi_state_type        state_r;
    logic [15:0]          tsel_r;
    logic [15:0]          opt_r;
    logic [15:0]          ctl_r    [NCH];
    logic [15:0]          sa_r     [NCH];
    logic [15:0]          da_r     [NCH];
    logic [15:0]          sz_r     [NCH];
    logic [NCH-1:0]       pend_r;
    logic [NCH-1:0]       lvl_r;
    logic [NCH-1:0]       lvl;
    logic [NCH-1:0]       done;
    logic [NCH-1:0]       ie;
    logic [NCH-1:0]       en;
    logic [NCH-1:0]       act;
    logic [NCH-1:0]       hi_clr;
    logic [NCH-1:0]       hw_set;
    logic [1:0]           cur_r;
    logic [1:0]           pick;
    logic [15:0]          iv_code;
    logic [15:0]          data_r;
    logic                 acc;
    logic                 wr_acc;
    logic                 mapped;
    logic                 iv_acc;
    logic                 busy;
    logic                 abort;
    logic                 conv_lvl;
    logic [8:0]           idx;
    logic [15:0]          rd_val;

    assign idx    = paddr[10:2];
    assign acc    = psel && penable && pready && mapped;
    assign wr_acc = acc && pwrite;
    assign iv_acc = acc && (idx == IDX_IV);
    assign busy   = (state_r != ST_IDLE);
    assign abort  = busy && nmi_request && opt_r[OPT_NMI_BIT];

    // --------------------------------------------------------------
    // CPU interaction
    // --------------------------------------------------------------
    // A running transfer keeps the bus; the CPU, inside an ISR or not, waits.
    assign cpu_bus_hold = busy;
    assign cpu_irq_take = cpu_irq_request && !busy;

    // --------------------------------------------------------------
    // Trigger selection and pending latch
    // --------------------------------------------------------------
    // Sequence modes 1 and 3 have bit 0 set and use the last memory.
    assign conv_lvl = conversion_sequence_mode[0] ?
                      converter_result_flag[conv_last_index] :
                      converter_result_flag[conv_used_index];

    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_ch
            always_comb begin
                done[gc] = ctl_r[gc][CH_DONE_BIT];
                ie[gc]   = ctl_r[gc][CH_IE_BIT];
                en[gc]   = ctl_r[gc][CH_EN_BIT];
                act[gc]  = done[gc] && ie[gc];
                case (tsel_r[gc*TSEL_W +: TSEL_W])
                    TSEL_I2C_RX: lvl[gc] = i2c_receive_flag && !i2c_receive_irq_enable;
                    TSEL_I2C_TX: lvl[gc] = i2c_transmit_flag && !i2c_transmit_irq_enable;
                    TSEL_CONV:   lvl[gc] = conv_lvl;
                    TSEL_DAC:    lvl[gc] = dac_load_flag;
                    TSEL_CHAIN:  lvl[gc] = ctl_r[(gc + NCH - 1) % NCH][CH_DONE_BIT];
                    TSEL_EXT:    lvl[gc] = ext_trigger;
                    default:     lvl[gc] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Edges, not levels, set pending so a flag still high during its clear does not retrigger.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lvl_r  <= '0;
            pend_r <= '0;
        end else begin
            lvl_r <= lvl;
            for (int c = 0; c < NCH; c++) begin
                if (!en[c]) begin
                    pend_r[c] <= 1'b0;
                end else if ((lvl[c] && !lvl_r[c]) ||
                             (wr_acc && idx == IDX_CH_CTL[c] && pwdata[CH_REQ_BIT])) begin
                    pend_r[c] <= 1'b1;
                end else if (state_r == ST_IDLE && pick == 2'(c)) begin
                    pend_r[c] <= 1'b0;
                end
            end
        end
    end

    // Fixed priority: channel 0 first.
    always_comb begin
        pick = 2'd3;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (pend_r[c] && en[c]) begin
                pick = 2'(c);
            end
        end
    end

    // --------------------------------------------------------------
    // Transfer engine
    // --------------------------------------------------------------
    // The engine never asks for the CPU clock to wake the core, so moves
    // continue whatever low-power state the CPU sits in.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= ST_IDLE;
            cur_r     <= 2'd0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 16'h0000;
            mem_wdata <= 16'h0000;
            data_r    <= 16'h0000;
        end else if (abort) begin
            state_r <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (pick != 2'd3) begin
                        cur_r    <= pick;
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_addr <= sa_r[pick];
                        state_r  <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (mem_ack) begin
                        data_r    <= mem_rdata;
                        mem_we    <= 1'b1;
                        mem_addr  <= da_r[cur_r];
                        mem_wdata <= mem_rdata;
                        state_r   <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we  <= 1'b0;
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Acknowledge and access side effects on peripheral flags.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            i2c_receive_flag_clear  <= 1'b0;
            i2c_transmit_flag_clear <= 1'b0;
            converter_flag_clear    <= 16'h0000;
            dac_load_flag_clear     <= 1'b0;
        end else begin
            i2c_receive_flag_clear  <= (state_r == ST_IDLE) && !abort && (pick != 2'd3) &&
                                       tsel_r[pick*TSEL_W +: TSEL_W] == TSEL_I2C_RX;
            i2c_transmit_flag_clear <= (state_r == ST_IDLE) && !abort && (pick != 2'd3) &&
                                       tsel_r[pick*TSEL_W +: TSEL_W] == TSEL_I2C_TX;
            converter_flag_clear    <= 16'h0000;
            if (mem_req && mem_ack && !mem_we && mem_addr[15:5] == CONV_BASE[15:5]) begin
                converter_flag_clear[mem_addr[4:1]] <= 1'b1;
            end
            dac_load_flag_clear     <= mem_req && mem_ack && mem_addr == DAC_DATA_A;
        end
    end

    // --------------------------------------------------------------
    // Interrupt vector
    // --------------------------------------------------------------
    always_comb begin
        iv_code = IV_NONE;
        hi_clr  = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (act[c]) begin
                iv_code = IV_CH[c];
                hi_clr  = '0;
                hi_clr[c] = 1'b1;
            end
        end
    end

    assign dma_irq = (|act) && global_irq_enable;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            hw_set[c] = !abort && state_r == ST_WRITE && mem_ack && cur_r == 2'(c) &&
                        sz_r[c] == ONE16;
        end
    end

    // --------------------------------------------------------------
    // Control registers, cleared by reset
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tsel_r <= CTL_RESET;
            opt_r  <= CTL_RESET;
            for (int c = 0; c < NCH; c++) begin
                ctl_r[c] <= CTL_RESET;
            end
        end else begin
            if (wr_acc && idx == IDX_TSEL) begin
                tsel_r <= pwdata[15:0] & TSEL_MASK;
            end
            if (wr_acc && idx == IDX_OPT) begin
                opt_r <= pwdata[15:0] & OPT_MASK;
            end
            for (int c = 0; c < NCH; c++) begin
                if (wr_acc && idx == IDX_CH_CTL[c]) begin
                    ctl_r[c] <= pwdata[15:0] & CH_CTL_MASK;
                end else if (iv_acc && hi_clr[c]) begin
                    ctl_r[c][CH_DONE_BIT] <= 1'b0;
                end
                // Hardware set wins over any same-cycle clear; hardware never clears it.
                if (hw_set[c]) begin
                    ctl_r[c][CH_DONE_BIT] <= 1'b1;
                    ctl_r[c][CH_EN_BIT]   <= 1'b0;
                end
                if (abort && cur_r == 2'(c)) begin
                    ctl_r[c][CH_ABORT_BIT] <= 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Address and size registers keep contents over reset
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (wr_acc && idx == IDX_CH_SA[c]) begin
                sa_r[c] <= pwdata[15:0];
            end
            if (wr_acc && idx == IDX_CH_DA[c]) begin
                da_r[c] <= pwdata[15:0];
            end
            if (wr_acc && idx == IDX_CH_SZ[c]) begin
                sz_r[c] <= pwdata[15:0];
            end else if (!abort && state_r == ST_WRITE && mem_ack && cur_r == 2'(c)) begin
                sz_r[c] <= sz_r[c] - ONE16;
            end
        end
    end

    // --------------------------------------------------------------
    // APB slave: one wait state, registered read data
    // --------------------------------------------------------------
    always_comb begin
        rd_val = 16'h0000;
        mapped = 1'b1;
        if (idx == IDX_TSEL) begin
            rd_val = tsel_r;
        end else if (idx == IDX_OPT) begin
            rd_val = opt_r;
        end else if (idx == IDX_IV) begin
            rd_val = iv_code;
        end else begin
            mapped = 1'b0;
            for (int c = 0; c < NCH; c++) begin
                if (idx == IDX_CH_CTL[c]) begin
                    rd_val = ctl_r[c];
                    mapped = 1'b1;
                end
                if (idx == IDX_CH_SA[c]) begin
                    rd_val = sa_r[c];
                    mapped = 1'b1;
                end
                if (idx == IDX_CH_DA[c]) begin
                    rd_val = da_r[c];
                    mapped = 1'b1;
                end
                if (idx == IDX_CH_SZ[c]) begin
                    rd_val = sz_r[c];
                    mapped = 1'b1;
                end
            end
        end
        if (paddr[11] || paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready) begin
                prdata <= (mapped && !pwrite) ? {16'h0000, rd_val} : 32'h00000000;
            end
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_last_write(int c);
        state_r == ST_WRITE && mem_ack && !abort && cur_r == 2'(c) && sz_r[c] == ONE16;
    endsequence

    sequence s_iv_touch;
        iv_acc && !(|hw_set);
    endsequence

    property p_irq_held;
        busy |-> !cpu_irq_take;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("irq taken during transfer");

    property p_nmi_abort;
        (busy && nmi_request && opt_r[OPT_NMI_BIT]) |=> state_r == ST_IDLE && !mem_req;
    endproperty
    a_nmi_abort: assert property (p_nmi_abort) else $error("nmi did not abort");

    property p_bus_hold;
        (state_r == ST_IDLE && pick != 2'd3) |=> cpu_bus_hold [*2];
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus not held");

    property p_done_set;
        s_last_write(0) |=> ctl_r[0][CH_DONE_BIT] && !ctl_r[0][CH_EN_BIT];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_irq_gate;
        dma_irq |-> global_irq_enable && (|(done & ie));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

    property p_iv_read;
        (psel && penable && !pready && !pwrite && idx == IDX_IV && act[0]) |=>
            prdata == {16'h0000, IV_CH[0]};
    endproperty
    a_iv_read: assert property (p_iv_read) else $error("vector not channel 0");

    property p_iv_masked;
        (act == 3'b000) |-> iv_code == IV_NONE;
    endproperty
    a_iv_masked: assert property (p_iv_masked) else $error("disabled channel in vector");

    property p_iv_clear;
        (s_iv_touch and act[0] && !wr_acc) |=> !done[0] && $stable(done[2]);
    endproperty
    a_iv_clear: assert property (p_iv_clear) else $error("vector access did not clear");

    property p_i2c_rx_clear;
        i2c_receive_flag_clear |-> $past(state_r) == ST_IDLE && state_r == ST_READ;
    endproperty
    a_i2c_rx_clear: assert property (p_i2c_rx_clear) else $error("stray receive clear");

    property p_dac_clear;
        (mem_req && mem_ack && mem_addr == DAC_DATA_A) |=> dac_load_flag_clear;
    endproperty
    a_dac_clear: assert property (p_dac_clear) else $error("dac flag not cleared");

endmodule

`default_nettype wire

// File: dv/dmi_mem_model.sv
// Memory model that answers the block's memory port.
`timescale 1ns/100ps
`default_nettype none
module dmi_mem_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    output logic      [15:0] mem_rdata,
    output logic             mem_ack
);
    logic [3:0] wait_r;
    // Read data toggles outside an answer, so a late capture never sees a stale word.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            wait_r <= 4'h0;
            mem_rdata <= 16'h0000;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (mem_req && !mem_ack) begin
                // The destination is always set up and, with slow set, answers after nine wait cycles, so every write lands.
                mem_ack <= 1'b1;
                wait_r <= slow ? 4'h9 : 4'h0;
                mem_rdata <= mem_addr ^ 16'h5A5A;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/dma_interrupt_trigger_and_regmap_bench.sv
// Self-checking bench for the DMA interrupt, trigger and register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t %h %h", $time, g, e); end end
module dma_interrupt_trigger_and_regmap_bench import dmi_pkg::*;;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, global_irq_enable, cpu_irq_request;
    logic cpu_irq_take, nmi_request, cpu_bus_hold, dma_irq, mem_req, mem_we, mem_ack, slow;
    logic i2c_receive_flag, i2c_receive_flag_clear, i2c_transmit_flag, i2c_transmit_flag_clear;
    logic dac_load_flag, dac_load_flag_clear, ext_trigger, i2c_receive_irq_enable;
    logic        i2c_transmit_irq_enable;
    logic [1:0]  conversion_sequence_mode, md;
    logic [2:0]  seen;
    logic [3:0]  conv_used_index, conv_last_index, idx;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] e_now, exp_q[$];
    logic [15:0] mem_addr, mem_wdata, mem_rdata, converter_result_flag, converter_flag_clear;
    logic [15:0] conv_seen, rd_a;
    int          num_errors, total_checks, cycles;
    dmi_core i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .global_irq_enable, .cpu_irq_request, .cpu_irq_take, .nmi_request, .cpu_bus_hold,
        .dma_irq, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .i2c_receive_flag,
        .i2c_receive_irq_enable, .i2c_receive_flag_clear, .i2c_transmit_flag, .i2c_transmit_irq_enable,
        .i2c_transmit_flag_clear, .converter_result_flag, .conversion_sequence_mode, .conv_used_index,
        .conv_last_index, .converter_flag_clear, .dac_load_flag, .dac_load_flag_clear, .ext_trigger);
    dmi_mem_model i_mem (.clk, .rstn, .slow, .mem_req, .mem_we, .mem_addr, .mem_rdata, .mem_ack);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [8:0] a, input logic [15:0] d, input logic [32:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        psel <= 1'b1; pwrite <= w; paddr <= {1'b0, a, 2'b00}; pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic setup(input int c, input logic [15:0] sa, input logic [15:0] ctl);
        apb(1'b1, IDX_CH_SA[c], sa, 33'h0); apb(1'b1, IDX_CH_DA[c], 16'h0200, 33'h0);
        // Enable first: a request written together with the enable is dropped.
        apb(1'b1, IDX_CH_SZ[c], 16'h0001, 33'h0); apb(1'b1, IDX_CH_CTL[c], ctl & 16'hFFFE, 33'h0);
        apb(1'b1, IDX_CH_CTL[c], ctl, 33'h0);
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // The I2C and DAC peripherals drop their flag on the clear pulse, as real sources would.
    always @(posedge clk) begin
        cycles++;
        if (psel && penable && pready === 1'b1) begin
            e_now = exp_q.pop_front();
            `CHK({pslverr, prdata}, e_now)
        end
        if (i2c_receive_flag_clear) begin seen[0] <= 1'b1; i2c_receive_flag <= 1'b0; end
        if (i2c_transmit_flag_clear) begin seen[1] <= 1'b1; i2c_transmit_flag <= 1'b0; end
        if (converter_flag_clear !== 16'h0000) begin seen[2] <= 1'b1; conv_seen <= converter_flag_clear; end
        if (dac_load_flag_clear) dac_load_flag <= 1'b0;
        if (mem_req && mem_ack && !mem_we) rd_a <= mem_addr;
        if (mem_req && mem_ack && mem_we) begin
            `CHK(mem_wdata, rd_a ^ 16'h5A5A)
            `CHK(mem_addr, 16'h0200)
        end
        if (cycles == 20000) begin num_errors++; test_done(); end
    end
    always @(negedge clk) if (rstn && cpu_bus_hold === 1'b1) `CHK(cpu_irq_take, 1'b0)
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, nmi_request, ext_trigger, dac_load_flag} = '0;
        {i2c_receive_flag, i2c_transmit_flag, i2c_receive_irq_enable, i2c_transmit_irq_enable} = '0;
        {converter_result_flag, conversion_sequence_mode, conv_used_index, conv_last_index} = '0;
        {seen, conv_seen, global_irq_enable, cpu_irq_request, rstn} = 22'h6;
        void'($urandom(98));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (IDX_CH_CTL[i]) apb(1'b0, IDX_CH_CTL[i], 16'h0000, 33'h0);
        apb(1'b0, IDX_IV, 16'h0000, 33'h0);
        apb(1'b0, 9'h100, 16'h0000, {1'b1, 32'h0});
        for (int c = 0; c < 3; c++) begin
            setup(c, 16'h0300, (c == 1) ? 16'h0011 : 16'h0015);
            repeat (3) @(posedge clk);
            while (cpu_bus_hold !== 1'b0) @(posedge clk);
        end
        `CHK(dma_irq, 1'b1)
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(dma_irq, 1'b0)
        global_irq_enable <= 1'b1;
        apb(1'b0, IDX_IV, 16'h0000, 33'h2);
        apb(1'b0, IDX_CH_CTL[0], 16'h0000, 33'h4);
        apb(1'b0, IDX_IV, 16'h0000, 33'h6);
        apb(1'b1, IDX_IV, 16'hFFFF, 33'h0);
        apb(1'b0, IDX_IV, 16'h0000, 33'h0);
        apb(1'b0, IDX_CH_CTL[1], 16'h0000, 33'h8);
        idx = 4'($urandom % 16);
        md = 2'($urandom % 4);
        conv_used_index <= md[0] ? ~idx : idx; conv_last_index <= md[0] ? idx : ~idx;
        conversion_sequence_mode <= md;
        apb(1'b1, IDX_TSEL, 16'h06DC, 33'h0);
        setup(0, 16'h0300, 16'h0010); setup(1, 16'h0300, 16'h0010);
        setup(2, CONV_BASE + {11'h000, idx, 1'b0}, 16'h0010);
        i2c_receive_flag <= 1'b1; i2c_transmit_flag <= 1'b1; converter_result_flag <= ONE16 << idx;
        while (seen !== 3'b111) @(posedge clk);
        `CHK(conv_seen, ONE16 << idx)
        apb(1'b1, IDX_TSEL, 16'h05EF, 33'h0);
        setup(0, 16'h0300, 16'h0010); setup(1, 16'h0300, 16'h0010);
        setup(2, DAC_DATA_A, 16'h0010);
        ext_trigger <= 1'b1; dac_load_flag <= 1'b1;
        repeat (40) @(posedge clk);
        `CHK(dac_load_flag, 1'b0)
        apb(1'b0, IDX_CH_CTL[1], 16'h0000, 33'h8);
        apb(1'b1, IDX_OPT, 16'h0001, 33'h0); apb(1'b1, IDX_TSEL, 16'h0000, 33'h0);
        slow <= 1'b1;
        setup(0, 16'h0300, 16'h0015);
        while (cpu_bus_hold !== 1'b1) @(posedge clk);
        nmi_request <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(cpu_bus_hold, 1'b0)
        apb(1'b1, IDX_CH_CTL[0], 16'h0000, 33'h0);
        `CHK(cpu_irq_take, 1'b1)
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, IDX_CH_SA[0], 16'h0000, 33'h300);
        apb(1'b0, IDX_OPT, 16'h0000, 33'h0);
        test_done();
    end
endmodule
`default_nettype wire
